// *** common/led_drv_pkg.sv ***
/*
 constants for the led pwm sync and gain control block.
 assumes a 250 mhz core clock and a 16-bit serial configuration word.
*/
// What this block does
// - sync bit clear: device itself coordinates handover, no pwm count lost
// - auto mode: new data takes over only at the end of a pwm cycle
// - sync bit set (default): new data copied to outputs at once
// - grayscale clock absent about one second: all outputs switched off
// - config bit 0 zero enables the timeout, one disables it
// - clock resumes after timeout: counters and comparators reset first
// - config bits 9 to 2 form an 8-bit gain code, 256 levels
// - config bit 9 selects low or high current band
// - config bits 8 to 2 are a 7-bit unsigned mantissa
// - gain equals ((1+3 band)/4) times ((1+3 mantissa/128)/2)
// - outputs staggered in four groups by index mod four, 8 clocks (32 ns) apart
// - config loaded when latch strobe spans 10 or 11 shift clock edges
// - only 12 bits of each 16-bit grayscale word drive the pwm
package led_drv_pkg;
   localparam int CH = 16;
   localparam int WORD_W = 16;
   localparam int GS_W = 12;
   localparam int CFG_W = 16;
   localparam logic [15:0] CFG_RST = 16'h06ac;
   localparam int CFG_TMO_DIS_BIT = 0;
   localparam int GAIN_LSB = 2;
   localparam int GAIN_MSB = 9;
   localparam int BAND_BIT = 9;
   localparam int MANT_MSB = 8;
   localparam int SYNC_BIT = 10;
   localparam logic [3:0] CMD_CFG_MIN = 4'ha;
   localparam logic [3:0] CMD_CFG_MAX = 4'hb;
   localparam logic [3:0] EDGE_CNT_MAX = 4'hf;
   localparam int GROUPS = 4;
   localparam int CLK_PERIOD_NS = 4;
   localparam int CLK_HZ = 250_000_000;
   localparam int STAGGER_NS = 30;
   localparam int STAGGER_CYC = (STAGGER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMEOUT_S = 1;
   localparam int TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;
   localparam int IDLE_W = 28;
   localparam int GAIN_NUM_W = 11;
   localparam logic [11:0] PWM_LAST = 12'hfff;
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_OFF = 2'b01,
      ST_RESTART = 2'b11
   } drv_state_e;
endpackage

// *** src/stagger_line.sv ***
/*
 staggered output line: delays each channel by its group index times
 a fixed step. assumes input and output on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module stagger_line
   import led_drv_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [CH-1:0] in_on,
   output logic [CH-1:0] out_on
);
   // =====================================================
   // delay line
   localparam int DEPTH = (GROUPS - 1) * STAGGER_CYC;
   logic [CH-1:0] sh_r [1:DEPTH];

   always_ff @(posedge clk) begin
      if (!nrst) begin
         for (int k = 1; k <= DEPTH; k++) sh_r[k] <= '0;
      end else begin
         sh_r[1] <= in_on;
         for (int k = 2; k <= DEPTH; k++) sh_r[k] <= sh_r[k-1];
      end
   end

   // =====================================================
   // taps per channel group
   genvar i;
   generate
      for (i = 0; i < CH; i++) begin : g_tap
         localparam int G = i % GROUPS;
         if (G == 0) begin : g_first
            always_ff @(posedge clk) begin
               if (!nrst) out_on[i] <= 1'b0;
               else out_on[i] <= in_on[i];
            end
         end else begin : g_late
            always_ff @(posedge clk) begin
               if (!nrst) out_on[i] <= 1'b0;
               else out_on[i] <= sh_r[G*STAGGER_CYC][i];
            end
         end
      end
   endgenerate
endmodule // stagger_line
`default_nettype wire

// *** src/led_pwm_sync_gain_ctrl.sv ***
/*
 output-side control of a 16-channel led driver: data handover,
 grayscale clock loss blanking, gain decode and staggered outputs.
 assumes pins are asynchronous and image data comes from same-clock logic.
*/
`timescale 1ns/1ps
`default_nettype none
module led_pwm_sync_gain_ctrl
   import led_drv_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic grayscale_clock,
   input wire logic serial_shift_clock,
   input wire logic latch_strobe,
   input wire logic serial_input,
   input wire logic [CH*WORD_W-1:0] image_data,
   input wire logic image_load,
   output logic [CH-1:0] current_sink_outputs,
   output logic current_band_select,
   output logic [6:0] gain_mantissa,
   output logic [GAIN_NUM_W-1:0] gain_numerator,
   output logic outputs_blanked
);
   // =====================================================
   // pin synchronisers
   logic [3:0] pin_a_r, pin_b_r, pin_c_r;
   logic grayscale_clock_rise, sclk_rise, lat_fall, lat_s, sdi_s;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pin_a_r <= '0;
         pin_b_r <= '0;
         pin_c_r <= '0;
      end else begin
         pin_a_r <= {serial_input, latch_strobe, serial_shift_clock,
                     grayscale_clock};
         pin_b_r <= pin_a_r;
         pin_c_r <= pin_b_r;
      end
   end

   assign grayscale_clock_rise = pin_b_r[0] & ~pin_c_r[0];
   assign sclk_rise = pin_b_r[1] & ~pin_c_r[1];
   assign lat_fall = ~pin_b_r[2] & pin_c_r[2];
   assign lat_s = pin_b_r[2];
   assign sdi_s = pin_b_r[3];

   // =====================================================
   // serial configuration load
   logic [CFG_W-1:0] shift_r, cfg_r;
   logic [3:0] edge_cnt_r;
   logic cfg_cmd;

   assign cfg_cmd = lat_fall && edge_cnt_r >= CMD_CFG_MIN
                    && edge_cnt_r <= CMD_CFG_MAX;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         shift_r <= '0;
         edge_cnt_r <= '0;
      end else begin
         if (sclk_rise) shift_r <= {shift_r[CFG_W-2:0], sdi_s};
         if (!lat_s) begin
            edge_cnt_r <= '0;
         end else if (sclk_rise && edge_cnt_r != EDGE_CNT_MAX) begin
            edge_cnt_r <= edge_cnt_r + 4'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) cfg_r <= CFG_RST;
      else if (cfg_cmd) cfg_r <= shift_r;
   end

   a_cfg_load: assert property (@(posedge clk) disable iff (!nrst)
      cfg_cmd |=> cfg_r == $past(shift_r))
      else $error("config word not loaded on write command");

   // =====================================================
   // gain decode
   logic band;
   logic [6:0] mant;
   logic [2:0] band_mul;
   logic [8:0] mant_term;

   assign band = cfg_r[BAND_BIT];
   assign mant = cfg_r[MANT_MSB:GAIN_LSB];
   assign band_mul = band ? 3'h4 : 3'h1;
   assign mant_term = 9'h080 + 9'(mant) * 9'h003;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         current_band_select <= 1'b0;
         gain_mantissa <= '0;
         gain_numerator <= '0;
      end else begin
         current_band_select <= band;
         gain_mantissa <= mant;
         gain_numerator <= GAIN_NUM_W'(band_mul * mant_term);
      end
   end

   a_gain_value: assert property (@(posedge clk) disable iff (!nrst)
      $past(nrst) |-> gain_numerator ==
         (($past(cfg_r[BAND_BIT]) ? 11'd4 : 11'd1) *
          (11'd128 + 11'd3 * 11'($past(cfg_r[MANT_MSB:GAIN_LSB])))))
      else $error("gain numerator does not follow config word");

   // =====================================================
   // clock loss state
   drv_state_e state_r;
   logic [IDLE_W-1:0] idle_r;
   logic tmo_en, idle_last;

   assign tmo_en = ~cfg_r[CFG_TMO_DIS_BIT];
   assign idle_last = idle_r == IDLE_W'(TIMEOUT_CYCLES - 1);

   always_ff @(posedge clk) begin
      if (!nrst) idle_r <= '0;
      else if (grayscale_clock_rise || state_r != ST_RUN) idle_r <= '0;
      else if (!idle_last) idle_r <= idle_r + IDLE_W'(1);
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_r <= ST_RUN;
      end else begin
         case (state_r)
            ST_RUN:
               if (!grayscale_clock_rise && tmo_en && idle_last) state_r <= ST_OFF;
            ST_OFF:
               if (grayscale_clock_rise) state_r <= ST_RESTART;
            ST_RESTART:
               state_r <= ST_RUN;
            default:
               state_r <= ST_OFF;
         endcase
      end
   end

   assign outputs_blanked = state_r != ST_RUN;

   a_timeout_fire: assert property (@(posedge clk) disable iff (!nrst)
      state_r == ST_RUN && tmo_en && idle_last && !grayscale_clock_rise
      |=> state_r == ST_OFF)
      else $error("clock loss did not blank outputs");

   a_timeout_disabled: assert property (@(posedge clk) disable iff (!nrst)
      state_r == ST_RUN && !tmo_en |=> state_r == ST_RUN)
      else $error("timeout fired while disabled");

   a_off_until_edge: assert property (@(posedge clk) disable iff (!nrst)
      state_r == ST_OFF && !grayscale_clock_rise |=> state_r == ST_OFF)
      else $error("outputs left blanking without clock edges");

   // =====================================================
   // pwm counter
   logic [GS_W-1:0] pwm_r;
   logic cycle_end;

   assign cycle_end = state_r == ST_RUN && grayscale_clock_rise && pwm_r == PWM_LAST;

   always_ff @(posedge clk) begin
      if (!nrst) pwm_r <= '0;
      else if (state_r == ST_OFF) pwm_r <= '0;
      else if (state_r == ST_RUN && grayscale_clock_rise) pwm_r <= pwm_r + GS_W'(1);
   end

   a_resume_reset: assert property (@(posedge clk) disable iff (!nrst)
      state_r == ST_OFF && grayscale_clock_rise
      |=> pwm_r == '0 && outputs_blanked ##1 pwm_r == '0)
      else $error("pwm counter not cleared on clock resume");

   // =====================================================
   // image data handover
   logic self_sync;
   logic [GS_W-1:0] act_r [CH];
   logic [GS_W-1:0] pend_r [CH];
   logic pend_v_r;
   logic [CH-1:0] raw_on_r;

   assign self_sync = cfg_r[SYNC_BIT];

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pend_v_r <= 1'b0;
      end else if (!self_sync && image_load) begin
         pend_v_r <= 1'b1;
      end else if (cycle_end || self_sync) begin
         pend_v_r <= 1'b0;
      end
   end

   genvar i;
   generate
      for (i = 0; i < CH; i++) begin : g_ch
         always_ff @(posedge clk) begin
            if (!nrst) begin
               pend_r[i] <= '0;
            end else if (!self_sync && image_load) begin
               pend_r[i] <= image_data[i*WORD_W +: GS_W];
            end
         end

         always_ff @(posedge clk) begin
            if (!nrst) begin
               act_r[i] <= '0;
            end else if (self_sync && image_load) begin
               act_r[i] <= image_data[i*WORD_W +: GS_W];
            end else if (!self_sync && cycle_end && pend_v_r) begin
               act_r[i] <= pend_r[i];
            end
         end

         always_ff @(posedge clk) begin
            if (!nrst) raw_on_r[i] <= 1'b0;
            else raw_on_r[i] <= state_r == ST_RUN && pwm_r < act_r[i];
         end
      end
   endgenerate

   a_self_immediate: assert property (@(posedge clk) disable iff (!nrst)
      self_sync && image_load |=> act_r[5] == $past(image_data[91:80]))
      else $error("self sync did not copy data at once");

   a_auto_holds: assert property (@(posedge clk) disable iff (!nrst)
      !self_sync && !cycle_end |=> act_r[2] == $past(act_r[2]))
      else $error("auto sync changed data inside a pwm cycle");

   a_auto_swap: assert property (@(posedge clk) disable iff (!nrst)
      !self_sync && pend_v_r && cycle_end |=> act_r[9] == $past(pend_r[9]))
      else $error("auto sync missed handover at cycle end");

   a_blank_off: assert property (@(posedge clk) disable iff (!nrst)
      outputs_blanked |=> raw_on_r == '0)
      else $error("channel on while blanked");

   // =====================================================
   // staggered outputs
   stagger_line u_stagger (
      .clk(clk),
      .nrst(nrst),
      .in_on(raw_on_r),
      .out_on(current_sink_outputs)
   );

   // cycles since reset, so the delay check never looks back into reset
   logic [4:0] age_r;

   always_ff @(posedge clk) begin
      if (!nrst) age_r <= '0;
      else if (age_r != 5'h1f) age_r <= age_r + 5'h01;
   end

   a_stagger_grp: assert property (@(posedge clk) disable iff (!nrst)
      age_r == 5'h1f |->
      current_sink_outputs[0] == $past(raw_on_r[0], 1) &&
      current_sink_outputs[1] == $past(raw_on_r[1], 9) &&
      current_sink_outputs[7] == $past(raw_on_r[7], 25))
      else $error("output group delay wrong");
endmodule // led_pwm_sync_gain_ctrl
`default_nettype wire

// *** test/host_model.sv ***
/*
 host controller model: grayscale clock pulses and serial config writes.
 assumes the bench calls one task at a time; clock and latch pins idle low between uses.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
   output logic grayscale_clock,
   output logic serial_shift_clock,
   output logic latch_strobe,
   output logic serial_input
);
   localparam realtime HALF = 62.5;
   initial begin
      grayscale_clock = 1'b0;
      serial_shift_clock = 1'b0;
      latch_strobe = 1'b0;
      serial_input = 1'b0;
   end
   // ==========================================
   // grayscale clock, stands low between bursts
   task automatic gs_pulse(input int n);
      repeat (n) begin
         #HALF grayscale_clock = 1'b1;
         #HALF grayscale_clock = 1'b0;
      end
   endtask
   // ==========================================
   // msb first, latch high over the last n shift rises
   task automatic write_cfg(input logic [15:0] w, input int n);
      for (int i = 15; i >= 0; i--) begin
         serial_input = w[i];
         if (i == n - 1) latch_strobe = 1'b1;
         #HALF serial_shift_clock = 1'b1;
         #HALF serial_shift_clock = 1'b0;
      end
      #HALF latch_strobe = 1'b0;
      serial_input = ~serial_input;
      #HALF;
   endtask
endmodule // host_model
`default_nettype wire

// *** test/led_pwm_sync_gain_ctrl_tb_top.sv ***
/*
 self-checking bench for led_pwm_sync_gain_ctrl.
 assumes host_model drives the pins and a short timeout parameter.
*/
`timescale 1ns/1ps
`default_nettype none
module led_pwm_sync_gain_ctrl_tb_top;
   import led_drv_pkg::*;
   localparam int TMO = 200;
   typedef struct {
      logic [7:0] code;
      logic band;
      logic [6:0] mant;
   } gain_row_s;
   gain_row_s rows [4] = '{'{8'hff, 1'b1, 7'h7f}, '{8'h80, 1'b1, 7'h00},
      '{8'h00, 1'b0, 7'h00}, '{8'h55, 1'b0, 7'h55}};
   logic clk, nrst, image_load;
   logic grayscale_clock, serial_shift_clock, latch_strobe, serial_input;
   logic [CH*WORD_W-1:0] image_data;
   logic [CH-1:0] current_sink_outputs;
   logic current_band_select, outputs_blanked;
   logic [6:0] gain_mantissa;
   logic [GAIN_NUM_W-1:0] gain_numerator;
   int failures, total_checks;
   led_pwm_sync_gain_ctrl #(.TIMEOUT_CYCLES(TMO)) uut (.clk(clk),
      .nrst(nrst), .grayscale_clock(grayscale_clock),
      .serial_shift_clock(serial_shift_clock), .latch_strobe(latch_strobe),
      .serial_input(serial_input), .image_data(image_data),
      .image_load(image_load), .current_sink_outputs(current_sink_outputs),
      .current_band_select(current_band_select),
      .gain_mantissa(gain_mantissa), .gain_numerator(gain_numerator),
      .outputs_blanked(outputs_blanked));
   host_model host (.grayscale_clock(grayscale_clock),
      .serial_shift_clock(serial_shift_clock), .latch_strobe(latch_strobe),
      .serial_input(serial_input));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ==========================================
   // helpers
   task automatic print_verdict();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [15:0] exp,
      input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wait_out(input logic [15:0] exp);
      int n;
      n = 0;
      while (current_sink_outputs !== exp && n < 400) begin
         @(negedge clk);
         n++;
      end
      if (n >= 400) begin
         failures++;
         $display("Error outputs wait expected %h seen %h", exp,
            current_sink_outputs);
         print_verdict();
      end
   endtask
   task automatic cfg(input logic [15:0] w);
      host.write_cfg(w, 10);
      repeat (8) @(negedge clk);
   endtask
   // group 3 channels get a word whose low 12 bits are zero
   task automatic load(input logic [15:0] w);
      @(negedge clk);
      for (int i = 0; i < CH; i++)
         image_data[16*i +: 16] = (i % 4 == 3) ? 16'hf000 : w;
      image_load = 1'b1;
      @(negedge clk);
      image_load = 1'b0;
   endtask
   // ==========================================
   // main sequence
   initial begin
      nrst = 1'b0;
      image_load = 1'b0;
      image_data = '0;
      failures = 0;
      total_checks = 0;
      repeat (10) @(negedge clk);
      nrst = 1'b1;
      repeat (2) @(negedge clk);
      check("numerator", 16'd1028, 16'(gain_numerator));
      check("band", 16'h1, 16'(current_band_select));
      check("outputs", 16'h0, current_sink_outputs);
      repeat (TMO + 20) @(negedge clk);
      check("blanked", 16'h1, 16'(outputs_blanked));
      foreach (rows[i]) begin
         cfg({6'h01, rows[i].code, 2'b01});
         check("band", 16'(rows[i].band), 16'(current_band_select));
         check("mantissa", 16'(rows[i].mant), 16'(gain_mantissa));
         check("numerator", 16'((1 + 3 * rows[i].band)
            * (128 + 3 * rows[i].mant)), 16'(gain_numerator));
      end
      host.write_cfg(16'h0401, 9);
      host.write_cfg(16'h07fd, 12);
      repeat (8) @(negedge clk);
      check("refused", 16'h0055, 16'(gain_mantissa));
      host.gs_pulse(1);
      repeat (8) @(negedge clk);
      check("blanked", 16'h0, 16'(outputs_blanked));
      load(16'hf001);
      wait_out(16'h1111);
      check("group0", 16'h1111, current_sink_outputs);
      repeat (8) @(negedge clk);
      check("group1", 16'h3333, current_sink_outputs);
      repeat (16) @(negedge clk);
      check("group3", 16'h7777, current_sink_outputs);
      repeat (TMO + 50) @(negedge clk);
      check("no timeout", 16'h7777, current_sink_outputs);
      cfg(16'h0400);
      repeat (40) @(negedge clk);
      check("timeout", 16'h0, current_sink_outputs);
      check("blanked", 16'h1, 16'(outputs_blanked));
      host.gs_pulse(1);
      wait_out(16'h7777);
      cfg(16'h0001);
      host.gs_pulse(3);
      repeat (40) @(negedge clk);
      check("counting", 16'h0, current_sink_outputs);
      load(16'h0fff);
      repeat (40) @(negedge clk);
      check("auto hold", 16'h0, current_sink_outputs);
      nrst = 1'b0;
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      check("reset out", 16'h0, current_sink_outputs);
      check("reset gain", 16'd1028, 16'(gain_numerator));
      print_verdict();
   end
endmodule // led_pwm_sync_gain_ctrl_tb_top
`default_nettype wire
